// ---- rtl/lvic_checker.sv ----
// Receiving end: pattern checker, word parity and block parity with sticky alarms.
// Assumes the link is asynchronous to CLOCK and slow enough to be oversampled.
`timescale 1ns/100ps
`include "lvic_defines.svh"
module lvic_checker
	import lvic_pkg::*;
#(
	parameter int KEY_WORDS = 8, // Words in the reference key.
	parameter int DATA_W = 16 // Width of the link data bus.
)(
	input wire logic CLOCK, // System clock.
	input wire logic SYS_RST, // Synchronous reset, active high.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB enable.
	input wire logic PWRITE, // APB direction.
	input wire logic [7:0] PADDR, // APB byte address.
	input wire logic [31:0] PWDATA, // APB write data.
	output logic [31:0] PRDATA, // APB read data.
	output logic PREADY, // APB ready.
	output logic PSLVERR, // APB error on unmapped address.
	input wire logic TX_ENABLE, // Transmit enable pin.
	output logic DAC_OUT_ENA, // Analog output enable.
	output logic ALARM, // Alarm pin, active high.
	lvic_link_if.dev LINK // Link from the data source.
);

	// The state record fixes both sizes, so no other value can be served.
	if (KEY_WORDS != 8 || DATA_W != 16) begin : g_bad_size
		$error("KEY_WORDS must be 8 and DATA_W must be 16");
	end

	lvic_dev_st_t s_r;
	lvic_dev_st_t s_nxt;

	logic rise;
	logic fall;
	logic [15:0] word;
	logic par;
	logic frm;
	logic marker;
	logic [7:0] ev;
	logic [15:0] err;
	logic hit;
	logic [31:0] rd;
	logic [15:0] loc_keep;
	logic [7:0] st_keep;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;

		// ----------------------------------------------------------------
		// Synchronisers and link edges
		// ----------------------------------------------------------------
		// Both stages come before any use, so every sampled line shares one delay.
		s_nxt.sync1 = {TX_ENABLE, LINK.dclk, LINK.parity, LINK.frame, LINK.sync, LINK.data};
		s_nxt.sync2 = s_r.sync1;
		s_nxt.dclk_d = s_r.sync2[19];
		// The word beside an edge has passed the same two stages, so it is still settled here.
		rise = s_r.sync2[19] & ~s_r.dclk_d;
		fall = ~s_r.sync2[19] & s_r.dclk_d;
		word = s_r.sync2[15:0];
		par = s_r.sync2[18];
		frm = s_r.sync2[17];
		marker = (s_r.syncsel == `LVIC_SYNCSEL_FRAME) ? frm : s_r.sync2[16];
		ev = 8'h00;
		err = 16'h0000;

		if (rise | fall) begin
			// ----------------------------------------------------------------
			// Pattern checker
			// ----------------------------------------------------------------
			// Before the first marker rise nothing is compared, so setup noise cannot flag.
			s_nxt.mk_prev = marker;
			if (s_r.ctrl[`LVIC_CTRL_PATTERN_BIT]) begin
				if (marker & ~s_r.mk_prev) begin
					err = word ^ s_r.key[0];
					s_nxt.idx = 3'h1;
					s_nxt.aligned = 1'b1;
				end else if (s_r.aligned) begin
					err = word ^ s_r.key[s_r.idx];
					s_nxt.idx = s_r.idx + 3'h1;
				end
			end else begin
				// Leaving pattern mode drops alignment, so a new run waits for a fresh marker.
				s_nxt.aligned = 1'b0;
				s_nxt.idx = 3'h0;
			end

			// ----------------------------------------------------------------
			// Word parity
			// ----------------------------------------------------------------
			// A timing fault often shows on one edge only, hence two separate flags.
			if (s_r.ctrl[`LVIC_CTRL_WORD_PAR_BIT] && ((^{word, par}) != s_r.ctrl[`LVIC_CTRL_ODD_BIT])) begin
				if (rise) begin
					ev[`LVIC_ALARM_RPAR_BIT] = 1'b1;
				end else begin
					ev[`LVIC_ALARM_FPAR_BIT] = 1'b1;
				end
			end

			// ----------------------------------------------------------------
			// Block parity
			// ----------------------------------------------------------------
			// Boundaries are found on rising captures only and judged on the next falling one; the sum takes every captured word.
			if (s_r.ctrl[`LVIC_CTRL_BLOCK_PAR_BIT]) begin
				if (rise) begin
					s_nxt.fr_prev = frm;
					if (frm & ~s_r.fr_prev) begin
						// The very first boundary closes a partial block, so it is not judged.
						s_nxt.pend = s_r.started;
						s_nxt.closed = s_r.acc;
						s_nxt.acc = ^word;
						s_nxt.started = 1'b1;
					end else begin
						s_nxt.acc = s_r.acc ^ (^word);
					end
				end else begin
					s_nxt.acc = s_r.acc ^ (^word);
					if (s_r.pend) begin
						s_nxt.pend = 1'b0;
						if (s_r.closed != frm) begin
							ev[`LVIC_ALARM_BLOCK_BIT] = 1'b1;
						end
					end
				end
			end else begin
				s_nxt.started = 1'b0;
				s_nxt.pend = 1'b0;
				s_nxt.acc = 1'b0;
				s_nxt.fr_prev = 1'b0;
			end
		end
		if (|err) begin
			ev[`LVIC_ALARM_PATTERN_BIT] = 1'b1;
		end

		// ----------------------------------------------------------------
		// APB slave: no wait states, answer prepared in the setup cycle
		// ----------------------------------------------------------------
		// Read data is chosen in the setup cycle, so the access phase never needs a wait state.
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (PADDR)
			`LVIC_TEST_CONTROL_OFFS: rd = {27'h0000000, s_r.ctrl};
			`LVIC_ERROR_LOCATION_OFFS: rd = {16'h0000, s_r.loc};
			`LVIC_ALARM_STATUS_OFFS: rd = {24'h000000, s_r.status};
			`LVIC_ALARM_MASK_OFFS: rd = {24'h000000, s_r.mask};
			`LVIC_SYNC_SELECT_OFFS: rd = {27'h0000000, s_r.syncsel};
			default: begin
				if ((PADDR[7:5] == `LVIC_KEY_BANK) && (PADDR[1:0] == 2'h0)) begin
					rd = {16'h0000, s_r.key[PADDR[4:2]]};
				end else begin
					hit = 1'b0;
				end
			end
		endcase

		// ----------------------------------------------------------------
		// Register writes, sticky flags and pins
		// ----------------------------------------------------------------
		// Status and location writes are masks: a one keeps a bit and a zero clears it.
		loc_keep = 16'hffff;
		st_keep = 8'hff;
		s_nxt.pready = 1'b0;
		if (PSEL & ~PENABLE) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = rd;
			s_nxt.pslverr = ~hit;
		end else if (PSEL & PENABLE & s_r.pready & PWRITE & hit) begin
			case (PADDR)
				`LVIC_TEST_CONTROL_OFFS: s_nxt.ctrl = PWDATA[4:0];
				`LVIC_ERROR_LOCATION_OFFS: loc_keep = PWDATA[15:0];
				`LVIC_ALARM_STATUS_OFFS: st_keep = PWDATA[7:0];
				`LVIC_ALARM_MASK_OFFS: s_nxt.mask = PWDATA[7:0];
				`LVIC_SYNC_SELECT_OFFS: s_nxt.syncsel = PWDATA[4:0];
				default: s_nxt.key[PADDR[4:2]] = PWDATA[15:0];
			endcase
		end
		// A new error in the clearing cycle wins over the clear.
		s_nxt.loc = (s_r.loc & loc_keep) | err;
		s_nxt.status = (s_r.status & st_keep) | ev;
		// The pin is registered from the stored flags, so it trails the status by one cycle.
		s_nxt.alarm = |(s_r.status & s_r.mask);
		// Pattern mode wins over both enables, so test words never reach the outputs.
		s_nxt.out_ena = s_r.sync2[20] & s_r.ctrl[`LVIC_CTRL_SW_TX_BIT] & ~s_r.ctrl[`LVIC_CTRL_PATTERN_BIT];
	end

	// Every field, the key words included, returns to zero on reset.
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign DAC_OUT_ENA = s_r.out_ena;
	assign ALARM = s_r.alarm;

endmodule

// ---- rtl/lvic_defines.svh ----
// Offsets, field positions, reset values and timing counts for the input integrity checker.
// Assumes 32-bit APB with 8-bit byte addresses; every register is one aligned word.
`ifndef LVIC_DEFINES_SVH
`define LVIC_DEFINES_SVH

// ----------------------------------------------------------------
// Device register map
// ----------------------------------------------------------------
`define LVIC_TEST_CONTROL_OFFS 8'h00
`define LVIC_ERROR_LOCATION_OFFS 8'h04
`define LVIC_ALARM_STATUS_OFFS 8'h08
`define LVIC_ALARM_MASK_OFFS 8'h0c
`define LVIC_SYNC_SELECT_OFFS 8'h10
`define LVIC_FIRST_KEY_OFFS 8'h20
`define LVIC_KEY_BANK 3'h1
`define LVIC_KEY_RESET 16'h0000
`define LVIC_CTRL_PATTERN_BIT 0
`define LVIC_CTRL_WORD_PAR_BIT 1
`define LVIC_CTRL_BLOCK_PAR_BIT 2
`define LVIC_CTRL_ODD_BIT 3
`define LVIC_CTRL_SW_TX_BIT 4
`define LVIC_ALARM_PATTERN_BIT 7
`define LVIC_ALARM_RPAR_BIT 2
`define LVIC_ALARM_FPAR_BIT 1
`define LVIC_ALARM_BLOCK_BIT 0
`define LVIC_SYNCSEL_FRAME 5'h00

// ----------------------------------------------------------------
// Source register map
// ----------------------------------------------------------------
`define LVIC_SRC_CTRL_OFFS 8'h00
`define LVIC_SRC_STATUS_OFFS 8'h04
`define LVIC_SRC_RUN_BIT 0
`define LVIC_SRC_ODD_BIT 1
`define LVIC_SRC_INJECT_BIT 2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LVIC_CLOCK_PERIOD_NS 10
`define LVIC_LINK_PERIOD_NS 160
`define LVIC_LINK_HALF_CYCLES (`LVIC_LINK_PERIOD_NS / `LVIC_CLOCK_PERIOD_NS / 2)

`endif

// ---- rtl/lvic_link_if.sv ----
// Link between the data source and the integrity checker.
// Assumes the source makes the link clock; the checker samples everything.
`timescale 1ns/100ps
interface lvic_link_if;
	logic dclk;
	logic [15:0] data;
	logic parity;
	logic frame;
	logic sync;
	modport dev(input dclk, input data, input parity, input frame, input sync);
	modport src(output dclk, output data, output parity, output frame, output sync);
endinterface

// ---- rtl/lvic_pkg.sv ----
// Types shared by both ends of the input integrity checker.
// Assumes nothing beyond the defines header.
package lvic_pkg;

	typedef struct packed {
		logic [20:0] sync1;
		logic [20:0] sync2;
		logic dclk_d;
		logic [4:0] ctrl;
		logic [15:0] loc;
		logic [7:0] status;
		logic [7:0] mask;
		logic [4:0] syncsel;
		logic [7:0][15:0] key;
		logic [2:0] idx;
		logic aligned;
		logic mk_prev;
		logic fr_prev;
		logic acc;
		logic closed;
		logic pend;
		logic started;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic alarm;
		logic out_ena;
	} lvic_dev_st_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic dclk;
		logic [15:0] data;
		logic parity;
		logic frame;
		logic sync;
		logic [2:0] ctrl;
		logic [7:0][15:0] key;
		logic [2:0] k;
		logic active;
		logic acc;
		logic last_par;
		logic [15:0] blocks;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} lvic_src_st_t;

endpackage

// ---- rtl/lvic_source.sv ----
// Sending end: derives the link clock and repeats the eight-word key with parity and markers.
// Assumes the checker samples the link with its own clock.
`timescale 1ns/100ps
`include "lvic_defines.svh"
module lvic_source
	import lvic_pkg::*;
#(
	parameter int HALF = `LVIC_LINK_HALF_CYCLES // System cycles per link clock half period.
)(
	input wire logic CLOCK, // System clock.
	input wire logic SYS_RST, // Synchronous reset, active high.
	input wire logic PSEL, // APB select.
	input wire logic PENABLE, // APB enable.
	input wire logic PWRITE, // APB direction.
	input wire logic [7:0] PADDR, // APB byte address.
	input wire logic [31:0] PWDATA, // APB write data.
	output logic [31:0] PRDATA, // APB read data.
	output logic PREADY, // APB ready.
	output logic PSLVERR, // APB error on unmapped address.
	lvic_link_if.src LINK // Link to the checker.
);

	localparam logic [7:0] HALF_C = 8'(HALF - 1);
	localparam logic [7:0] MID_C = 8'(HALF / 2 - 1);

	if (HALF < 4 || HALF > 255) begin : g_bad_half
		$error("HALF must lie between 4 and 255");
	end

	lvic_src_st_t s_r;
	lvic_src_st_t s_nxt;

	logic [15:0] w;
	logic hit;
	logic [31:0] rd;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		w = s_r.key[s_r.k];
		s_nxt.cnt = (s_r.cnt == HALF_C) ? 8'h00 : s_r.cnt + 8'h01;
		if (s_r.cnt == HALF_C) begin
			s_nxt.dclk = ~s_r.dclk;
		end
		// Words change mid-way between link edges so each edge meets settled data.
		if (s_r.cnt == MID_C) begin
			if (s_r.active | (s_r.ctrl[`LVIC_SRC_RUN_BIT] & ~s_r.dclk)) begin
				s_nxt.active = 1'b1;
				s_nxt.data = w ^ {15'h0000, s_r.ctrl[`LVIC_SRC_INJECT_BIT]};
				s_nxt.parity = (^w) ^ s_r.ctrl[`LVIC_SRC_ODD_BIT];
				s_nxt.sync = (s_r.k == 3'h0);
				s_nxt.frame = (s_r.k == 3'h0) | ((s_r.k == 3'h1) & s_r.last_par);
				if (s_r.k == 3'h0) begin
					s_nxt.last_par = s_r.acc;
					s_nxt.acc = ^w;
					s_nxt.blocks = s_r.blocks + 16'h0001;
				end else begin
					s_nxt.acc = s_r.acc ^ (^w);
				end
				s_nxt.k = s_r.k + 3'h1;
				if ((s_r.k == 3'h7) & ~s_r.ctrl[`LVIC_SRC_RUN_BIT]) begin
					s_nxt.active = 1'b0;
				end
			end
		end

		// ----------------------------------------------------------------
		// APB slave
		// ----------------------------------------------------------------
		hit = 1'b1;
		rd = 32'h0000_0000;
		case (PADDR)
			`LVIC_SRC_CTRL_OFFS: rd = {29'h00000000, s_r.ctrl};
			`LVIC_SRC_STATUS_OFFS: rd = {15'h0000, s_r.active, s_r.blocks};
			default: begin
				if ((PADDR[7:5] == `LVIC_KEY_BANK) && (PADDR[1:0] == 2'h0)) begin
					rd = {16'h0000, s_r.key[PADDR[4:2]]};
				end else begin
					hit = 1'b0;
				end
			end
		endcase
		s_nxt.pready = 1'b0;
		if (PSEL & ~PENABLE) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = rd;
			s_nxt.pslverr = ~hit;
		end else if (PSEL & PENABLE & s_r.pready & PWRITE & hit) begin
			if (PADDR == `LVIC_SRC_CTRL_OFFS) begin
				s_nxt.ctrl = PWDATA[2:0];
			end else if (PADDR[7:5] == `LVIC_KEY_BANK) begin
				s_nxt.key[PADDR[4:2]] = PWDATA[15:0];
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign LINK.dclk = s_r.dclk;
	assign LINK.data = s_r.data;
	assign LINK.parity = s_r.parity;
	assign LINK.frame = s_r.frame;
	assign LINK.sync = s_r.sync;

endmodule

// ---- verification/lvds_input_integrity_checker_tb.sv ----
// Testbench joining the data source and the integrity checker over the link.
// Assumes both ends answer APB with a one-cycle access phase.
`timescale 1ns/100ps
module lvds_input_integrity_checker_tb;
	localparam int HALF = 8;
	logic clock = 0, sys_rst = 1, psel_d = 0, psel_s = 0, penable = 0, pwrite = 0, tx_en = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prd_d, prd_s;
	logic rdy_d, rdy_s, err_d, err_s, dac_ena, alarm;
	int err_count = 0, checks_done = 0;
	logic [32:0] exp_q[$];
	logic [15:0] key[8];
	always #5 clock = ~clock;
	lvic_link_if lnk();
	lvic_checker u_lvic_checker(.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel_d), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prd_d), .PREADY(rdy_d), .PSLVERR(err_d),
		.TX_ENABLE(tx_en), .DAC_OUT_ENA(dac_ena), .ALARM(alarm), .LINK(lnk));
	lvic_source #(.HALF(HALF)) u_lvic_source(.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel_s),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prd_s),
		.PREADY(rdy_s), .PSLVERR(err_s), .LINK(lnk));
	lvic_link_sva #(.HALF(HALF)) u_lvic_link_sva(.CLOCK(clock), .SYS_RST(sys_rst), .dclk(lnk.dclk),
		.data(lnk.data), .parity(lnk.parity), .frame(lnk.frame), .sync(lnk.sync), .PSEL(psel_d),
		.PENABLE(penable), .PWRITE(pwrite), .TX_ENABLE(tx_en), .DAC_OUT_ENA(dac_ena), .ALARM(alarm));
	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic pin(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic s, input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_d <= !s;
		psel_s <= s;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if ((s ? rdy_s : rdy_d) === 1'b1) break;
		end
		if (n == 20) begin
			err_count++;
			$display("[ERR] %0t no ready within 20 cycles", $time);
			test_done();
		end
		psel_d <= 1'b0;
		psel_s <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, 1'b0, a, 32'h0);
	endtask
	task automatic rds(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b1, 1'b0, a, 32'h0);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Each completed read on either bus takes the oldest expectation.
	always @(posedge clock) begin
		if (penable && !pwrite && ((psel_d && rdy_d === 1'b1) || (psel_s && rdy_s === 1'b1))) begin
			if (exp_q.size() == 0) pin(1'b1, 1'b0);
			else cmp(psel_s ? {err_s, prd_s} : {err_d, prd_d}, exp_q.pop_front());
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h6573));
		foreach (key[i]) key[i] = 16'($urandom());
		wt(12);
		sys_rst <= 1'b0;
		@(posedge clock);
		rd(8'h00, 33'h0);
		rd(8'h3c, 33'h0);
		rd(8'h40, 33'h1_0000_0000);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 1'b1, 8'(8'h20 + 4 * i), {16'h0, key[i]});
			apb(1'b1, 1'b1, 8'(8'h20 + 4 * i), {16'h0, key[i]});
		end
		apb(1'b0, 1'b1, 8'h10, 32'h1);
		apb(1'b0, 1'b1, 8'h0c, 32'hff);
		apb(1'b0, 1'b1, 8'h00, 32'h1f);
		tx_en <= 1'b1;
		wt(8);
		pin(dac_ena, 1'b0);
		apb(1'b1, 1'b1, 8'h00, 32'h3);
		rds(8'h00, 33'h3);
		rds(8'h3c, {17'h0, key[7]});
		wt(6500);
		apb(1'b0, 1'b1, 8'h04, 32'h0);
		apb(1'b0, 1'b1, 8'h08, 32'h0);
		wt(200);
		rd(8'h04, 33'h0);
		rd(8'h08, 33'h0);
		// Injection starts mid-block, so the first partial block is cleared away.
		apb(1'b1, 1'b1, 8'h00, 32'h7);
		wt(200);
		apb(1'b0, 1'b1, 8'h08, 32'h0);
		wt(200);
		rd(8'h04, 33'h1);
		rd(8'h08, 33'h86);
		pin(alarm, 1'b1);
		apb(1'b0, 1'b1, 8'h0c, 32'h0);
		wt(4);
		pin(alarm, 1'b0);
		apb(1'b0, 1'b1, 8'h08, 32'h0);
		wt(40);
		rd(8'h08, 33'h86);
		apb(1'b0, 1'b1, 8'h10, 32'h0);
		apb(1'b1, 1'b1, 8'h00, 32'h1);
		wt(200);
		apb(1'b0, 1'b1, 8'h04, 32'h0);
		apb(1'b0, 1'b1, 8'h08, 32'h0);
		wt(200);
		rd(8'h04, 33'h0);
		rd(8'h08, 33'h6);
		apb(1'b0, 1'b1, 8'h00, 32'h10);
		wt(8);
		pin(dac_ena, 1'b1);
		tx_en <= 1'b0;
		wt(8);
		pin(dac_ena, 1'b0);
		pin(exp_q.size() == 0, 1'b1);
		test_done();
	end
endmodule

// ---- verification/lvic_link_sva.sv ----
// Concurrent checks on the link and the checker's pins.
// Assumes the testbench instantiates it beside the link interface.
`timescale 1ns/100ps
module lvic_link_sva #(
	parameter int HALF = 8 // System cycles per link half period.
)(
	input wire logic CLOCK, // System clock.
	input wire logic SYS_RST, // Reset.
	input wire logic dclk, // Link clock.
	input wire logic [15:0] data, // Link data.
	input wire logic parity, // Parity lane.
	input wire logic frame, // Boundary marker.
	input wire logic sync, // Sync marker.
	input wire logic PSEL, // Checker select.
	input wire logic PENABLE, // Enable.
	input wire logic PWRITE, // Direction.
	input wire logic TX_ENABLE, // Transmit enable pin.
	input wire logic DAC_OUT_ENA, // Output enable.
	input wire logic ALARM // Alarm pin.
);
	logic [7:0] run_r;
	logic [7:0] sh_r;
	logic [2:0] edge_r;
	logic seen_r;
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	// The run counter saturates so a stopped link clock cannot wrap it.
	always_ff @(posedge CLOCK) begin
		run_r <= (SYS_RST || $changed(dclk)) ? 8'h00 : run_r + {7'h00, run_r != 8'hff};
		sh_r <= (SYS_RST || !sync) ? 8'h00 : sh_r + 8'h01;
		// Link edges since the last marker rise, kept modulo eight.
		edge_r <= (SYS_RST || $rose(frame)) ? 3'h0 : edge_r + {2'h0, $changed(dclk)};
		seen_r <= !SYS_RST && (seen_r || $rose(frame));
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_half; $changed(dclk) |-> run_r >= 8'(HALF - 1); endproperty
	a_half: assert property (p_half) else $error("link clock half period too short");
	property p_setup; $changed(dclk) |-> $stable(data) && $stable(parity); endproperty
	a_setup: assert property (p_setup) else $error("data moved at a link edge");
	property p_sync; $rose(sync) |-> !dclk; endproperty
	a_sync: assert property (p_sync) else $error("key word zero not on a rising edge");
	property p_frame; $rose(frame) |-> sync; endproperty
	a_frame: assert property (p_frame) else $error("marker rise away from word zero");
	property p_block; $rose(frame) && seen_r |-> edge_r == 3'h0; endproperty
	a_block: assert property (p_block) else $error("parity block not a whole number of eight words");
	property p_synclen; $fell(sync) |-> sh_r == 8'(HALF); endproperty
	a_synclen: assert property (p_synclen) else $error("sync not one word long");
	property p_rst; $fell(SYS_RST) |-> !dclk && !sync && !frame && !ALARM; endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_txoff; $fell(TX_ENABLE) |-> ##[1:4] !DAC_OUT_ENA; endproperty
	a_txoff: assert property (p_txoff) else $error("outputs stay on without enable");
	property p_txon; $rose(DAC_OUT_ENA) |-> TX_ENABLE && $past(TX_ENABLE, 2); endproperty
	a_txon: assert property (p_txon) else $error("outputs on without enable");
	property p_sticky; $fell(ALARM) |-> $past(PSEL && PENABLE && PWRITE, 2); endproperty
	a_sticky: assert property (p_sticky) else $error("alarm dropped without a write");
	c_sync: cover property ($rose(sync));
	c_alarm: cover property ($rose(ALARM));
	c_off: cover property ($fell(DAC_OUT_ENA));
endmodule
